// [rtl/dbc_bridge_chopper.sv]
// Purpose: Off-time chopper and gate pattern for one full bridge.
// Assumes: Comparator and sequencer inputs are already synchronised.
// Notes:   Gates are registered, chopOff is decoded from the state register; one instance per bridge.
`default_nettype none
module dbc_bridge_chopper
   import dbc_pkg::*;
(
   input  wire logic        clock,      // System clock.
   input  wire logic        rst_n,      // Asynchronous reset, active low.
   input  wire logic        enLine,     // Synchronised enable line level.
   input  wire logic        slowDecay,  // Decay select, high for slow decay.
   input  wire dbc_seq_s    seq,        // Phase and enable of this bridge.
   input  wire logic        overRef,    // Sense above reference.
   input  wire dbc_timing_s timing,     // Programmed cycle counts.
   output var  dbc_gates_s  gates,      // Registered gate drive.
   output var  logic        chopOff     // High while bridge is chopped off.
);
   typedef struct packed {
      dbc_chop_e  st;
      dbc_cnt_t   cnt;
      dbc_cnt_t   onCnt;
      logic       fast;
      dbc_gates_s g;
   } dbc_bst_s;

   dbc_bst_s s_reg;
   dbc_bst_s s_next;

   // Counter step with saturation at the top.
   function automatic dbc_cnt_t incSat(input dbc_cnt_t v);
      return (v == '1) ? v : dbc_cnt_t'(v + 1'b1);
   endfunction

   // Chopper state, timers and gate pattern.
   always_comb begin
      logic dirA;
      logic armed;
      dirA   = seq.phase;
      armed  = 1'b0;
      s_next = s_reg;
      s_next.cnt   = incSat(s_reg.cnt);
      s_next.onCnt = incSat(s_reg.onCnt);
      unique case (s_reg.st)
         CH_IDLE: begin
            s_next.st  = CH_DEAD_ON;
            s_next.cnt = '0;
         end
         CH_ON: begin
            // Comparator ignored in blanking and minimum on time.
            armed = (s_reg.onCnt >= timing.blankTime) && (s_reg.onCnt >= timing.minOn);
            if (armed && overRef) begin
               s_next.st   = CH_DEAD_OFF;
               s_next.cnt  = '0;
               s_next.fast = !slowDecay;
            end
         end
         CH_DEAD_OFF: begin
            // One-shot runs from the trip; dead time first.
            if (s_reg.cnt + 1'b1 >= timing.deadTime) begin
               s_next.st = CH_RECIRC;
            end
         end
         CH_RECIRC: begin
            if (s_reg.cnt + 1'b1 >= timing.offTime) begin
               s_next.st  = CH_DEAD_ON;
               s_next.cnt = '0;
            end
         end
         CH_DEAD_ON: begin
            // Turn-on only after a further dead interval.
            if (s_reg.cnt + 1'b1 >= timing.deadTime) begin
               s_next.st    = CH_ON;
               s_next.onCnt = '0;
            end
         end
      endcase
      // Gate pattern from chopper state and sequencer.
      s_next.g = '0;
      if (seq.enable) begin
         unique case (s_next.st)
            CH_ON: begin
               s_next.g.hi1 = dirA;
               s_next.g.lo2 = dirA;
               s_next.g.hi2 = !dirA;
               s_next.g.lo1 = !dirA;
            end
            CH_DEAD_OFF: begin
               // Fast decay drops both; slow keeps the high side.
               if (!s_next.fast) begin
                  s_next.g.hi1 = dirA;
                  s_next.g.hi2 = !dirA;
               end
            end
            CH_RECIRC: begin
               if (s_next.fast) begin
                  // Only the low side beside the diode conducts.
                  s_next.g.lo1 = dirA;
                  s_next.g.lo2 = !dirA;
               end else begin
                  // Both high sides for synchronous rectification.
                  s_next.g.hi1 = 1'b1;
                  s_next.g.hi2 = 1'b1;
               end
            end
            CH_DEAD_ON: begin
               if (!s_next.fast) begin
                  s_next.g.hi1 = dirA;
                  s_next.g.hi2 = !dirA;
               end
            end
            default: begin
               s_next.g = '0;
            end
         endcase
      end
      // Low enable line holds all off and restarts the chopper.
      if (!enLine) begin
         s_next.st    = CH_IDLE;
         s_next.cnt   = '0;
         s_next.onCnt = '0;
         s_next.fast  = 1'b0;
         s_next.g     = '0;
      end
   end

   // State register.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: CH_IDLE, cnt: '0, onCnt: '0, fast: 1'b0, g: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign gates   = s_reg.g;
   assign chopOff = (s_reg.st == CH_DEAD_OFF) || (s_reg.st == CH_RECIRC);
endmodule
`default_nettype wire

// [rtl/dbc_dual_chopper.sv]
// Purpose: Dual bridge constant off-time current chopper with pump drive.
// Assumes: 20 MHz clock; Wishbone classic slave for timing registers.
// Notes:   Enable line is wired low; this block drives it open drain.
//
// Functional notes
// - Two independent choppers, sharing only timing, decay select and enable line.
// - Dead interval between leg transistor switching.
// - Comparator above reference fires the one-shot.
// - Off for one-shot time, then back on.
// - Effective off period adds dead interval.
// - Blanking window ignores comparator after turn-on.
// - Minimum on period before next chop.
// - Decay low: fast decay, both off.
// - Decay high: slow decay, low side off.
// - Fast decay recirculates via low side only.
// - Fast decay turn-on after dead interval.
// - Slow decay: opposite high side rectifies.
// - Slow decay low side returns after dead.
// - Pattern combines chopper with sequencer signals.
// - Enable line is wired low, open drain.
// - Free-running pump drive square wave.
// - Sequencer gives phase and enable per bridge.
// - Fault pulls enable line low.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
module dbc_dual_chopper
   import dbc_pkg::*;
(
   input  wire logic        clock,          // System clock, 20 MHz.
   input  wire logic        rst_n,          // Asynchronous reset, active low.
   input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
   input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
   output var  logic [31:0] wb_dat_o,       // Wishbone read data.
   input  wire logic        wb_we_i,        // Wishbone write enable.
   input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
   input  wire logic        wb_cyc_i,       // Wishbone cycle.
   input  wire logic        wb_stb_i,       // Wishbone strobe.
   output var  logic        wb_ack_o,       // Wishbone acknowledge.
   input  wire logic        enLine_i,       // Enable line level from pin.
   output var  logic        enLine_o,       // Enable line drive value, low.
   output var  logic        enLine_oe_n,    // Enable line pull-down, low drives.
   input  wire logic        faultOver,      // High-side overcurrent fault.
   input  wire logic        decaySel,       // Decay select, high slow.
   input  wire dbc_seq_s    seqA,           // Sequencer phase and enable, bridge A.
   input  wire dbc_seq_s    seqB,           // Sequencer phase and enable, bridge B.
   input  wire logic        overRefA,       // Sense A above reference.
   input  wire logic        overRefB,       // Sense B above reference.
   output var  dbc_gates_s  gatesA,         // Gate drive bridge A.
   output var  dbc_gates_s  gatesB,         // Gate drive bridge B.
   output var  logic        pump_drive_out  // Charge pump square wave.
);
   // Register map, 16-bit fields.

   // 0x00: off time from trip.

   // 0x04: dead interval.

   // 0x08: blanking window.

   // 0x0c: minimum on period.

   // 0x10: read-only status.

   // Status bit 9: fault pull-down.

   // Status bit 8: line level.

   // Bits 7:4: bridge A gates.

   // Bits 3:0: bridge B gates.

   // Unmapped reads give zero.

   // Ack comes one cycle late.

   // Ack and data stand one cycle.

   // Held strobes ack every other cycle.

   // Pins pass two flip-flops.

   // Faults cut gates in six edges.

   // Timing writes act at once.

   // Program with the line held low.

   // A dead time under two cycles is unsafe.

   // Width of the pin bundle.
   localparam int unsigned SYNC_W = 9;

   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      dbc_timing_s       timing;
      logic [31:0]       rdData;
      logic              ack;
      logic              pullLow;
      dbc_cnt_t          pumpCnt;
      logic              pump;
   } dbc_top_s;

   // Registered state and its next value.
   dbc_top_s   s_reg;
   dbc_top_s   s_next;

   // Raw pin bundle.
   logic [SYNC_W-1:0] rawIn;

   // Synchronised control levels.
   logic       enSync;
   logic       decSync;
   logic       faultSync;

   // Synchronised sequencer inputs.
   dbc_seq_s   seqASync;
   dbc_seq_s   seqBSync;

   // Synchronised comparators.
   logic       cmpASync;
   logic       cmpBSync;

   // Chopper results.
   dbc_gates_s gatesANext;
   dbc_gates_s gatesBNext;
   logic       chopA;
   logic       chopB;

   // Byte-lane merge for register writes.
   function automatic dbc_cnt_t laneWrite(input dbc_cnt_t old, input logic [31:0] d,
                                          input logic [3:0] sel);
      dbc_cnt_t r;
      r = old;
      // Lanes 2 and 3 have no storage.
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end

      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Pin inputs, each passed through two flip-flops.
   assign rawIn     = {enLine_i, decaySel, faultOver, seqA, seqB, overRefA, overRefB};

   // Only the second stage is read.
   assign enSync    = s_reg.sync2[8];

   assign decSync   = s_reg.sync2[7];

   assign faultSync = s_reg.sync2[6];

   assign seqASync  = s_reg.sync2[5:4];

   assign seqBSync  = s_reg.sync2[3:2];

   assign cmpASync  = s_reg.sync2[1];

   assign cmpBSync  = s_reg.sync2[0];

   // Synchronisers, register port, fault pull-down and pump divider.
   always_comb begin
      logic access;
      access = wb_cyc_i && wb_stb_i && !s_reg.ack;
      s_next = s_reg;

      // Two stage synchroniser shift.
      s_next.sync1 = rawIn;
      s_next.sync2 = s_reg.sync1;

      // Ack pulses after a request.
      s_next.ack   = access;

      // Read data is zero when idle.
      s_next.rdData = '0;

      // Timing registers steer both choppers.
      if (access) begin
         unique case (wb_adr_i)
            // Off time field.
            REG_OFF_TIME: begin
               s_next.rdData = 32'(s_reg.timing.offTime);
               if (wb_we_i) begin
                  s_next.timing.offTime = laneWrite(s_reg.timing.offTime, wb_dat_i, wb_sel_i);
               end
            end

            // Dead interval field.
            REG_DEAD_TIME: begin
               s_next.rdData = 32'(s_reg.timing.deadTime);
               if (wb_we_i) begin
                  s_next.timing.deadTime = laneWrite(s_reg.timing.deadTime, wb_dat_i, wb_sel_i);
               end
            end

            // Blanking field.
            REG_BLANK_TIME: begin
               s_next.rdData = 32'(s_reg.timing.blankTime);
               if (wb_we_i) begin
                  s_next.timing.blankTime = laneWrite(s_reg.timing.blankTime, wb_dat_i,
                                                      wb_sel_i);
               end
            end

            // Minimum on field.
            REG_MIN_ON: begin
               s_next.rdData = 32'(s_reg.timing.minOn);
               if (wb_we_i) begin
                  s_next.timing.minOn = laneWrite(s_reg.timing.minOn, wb_dat_i, wb_sel_i);
               end
            end

            // Status word, read only.
            REG_STATUS: begin
               s_next.rdData = {22'h000000, s_reg.pullLow, enSync, gatesA, gatesB};
            end

            // Unmapped offsets.
            default: begin
               s_next.rdData = '0;
            end
         endcase
      end

      // Fault holds the open-drain pull-down while present.
      // The fault's duration sets the low time; the pull-down lets go the cycle after it clears.
      s_next.pullLow = faultSync;

      // Free-running pump divider.
      // Half period rounds down, so it runs fast.
      if (s_reg.pumpCnt + 1'b1 >= dbc_cnt_t'(PUMP_HALF_CYC)) begin
         s_next.pumpCnt = '0;
         s_next.pump    = !s_reg.pump;
      end else begin
         s_next.pumpCnt = dbc_cnt_t'(s_reg.pumpCnt + 1'b1);
      end
   end

   // State register and output registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{sync1: '0, sync2: '0,
                    timing: '{offTime: RST_OFF, deadTime: RST_DEAD,
                              blankTime: RST_BLANK, minOn: RST_MINON},
                    rdData: '0, ack: 1'b0, pullLow: 1'b0, pumpCnt: '0, pump: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // One chopper per bridge, no shared state.
   // Shared timing, private counters.
   // The chopOff flags are spare taps.
   dbc_bridge_chopper u_chopA (
      .clock     (clock),
      .rst_n     (rst_n),
      .enLine    (enSync),
      .slowDecay (decSync),
      .seq       (seqASync),
      .overRef   (cmpASync),
      .timing    (s_reg.timing),
      .gates     (gatesANext),
      .chopOff   (chopA)
   );

   // Bridge B has its own inputs.
   dbc_bridge_chopper u_chopB (
      .clock     (clock),
      .rst_n     (rst_n),
      .enLine    (enSync),
      .slowDecay (decSync),
      .seq       (seqBSync),
      .overRef   (cmpBSync),
      .timing    (s_reg.timing),
      .gates     (gatesBNext),
      .chopOff   (chopB)
   );

   // Chopper timeline per bridge.

   // Reset or a low line leaves it idle.

   // Idle lasts one cycle, then one dead interval.

   // Then the bridge turns on.

   // Blanking masks the comparator.

   // Minimum on time masks it too.

   // A trip starts the off time.

   // Fast decay opens with all gates low.

   // Slow decay keeps the high side on.

   // Recirculation fills the rest.

   // Fast decay rectifies on one low side.

   // Slow decay uses both high sides.

   // Then a dead interval again.

   // Off time plus dead interval
   // gives the whole off period.

   // Sequencer enable low: all off.

   // Phase picks the diagonal.

   // A low line resets all state.

   // The pump runs through faults.

   // Counters saturate, never wrap.

   // Settings apply next cycle.

   // Writes never stall the choppers.

   // Gates change only on edges.

   // Legs never conduct together.

   // A new trip needs a new on period.

   // Outputs straight from flip-flops, but enLine_oe_n is an inverted flip-flop and enLine_o a constant.

   // Gates are registered per chopper.

   // The enable drive is a constant low.
   assign gatesA         = gatesANext;
   assign gatesB         = gatesBNext;
   assign wb_dat_o       = s_reg.rdData;
   assign wb_ack_o       = s_reg.ack;
   assign pump_drive_out = s_reg.pump;
   assign enLine_o       = 1'b0;
   assign enLine_oe_n    = !s_reg.pullLow;
endmodule
`default_nettype wire

// [rtl/dbc_pkg.sv]
// Purpose: Shared constants and types for the dual bridge off-time chopper.
// Assumes: 20 MHz clock; Wishbone classic register port with 32-bit data.
// Notes:   Times are kept in ns and converted to cycles here.
`default_nettype none
package dbc_pkg;
   localparam int unsigned CLK_PERIOD_NS    = 50;
   localparam int unsigned DEAD_NS          = 1000;
   localparam int unsigned BLANK_NS         = 1000;
   localparam int unsigned MIN_ON_NS        = 1500;
   localparam int unsigned OFF_NS           = 6600;
   localparam int unsigned PUMP_HZ          = 600000;
   localparam int unsigned CLK_HZ           = 20000000;
   // Least times round up to whole cycles.
   localparam int unsigned DEAD_CYC   = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BLANK_CYC  = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OFF_CYC    = (OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Half period of the pump square wave, rounded down.
   localparam int unsigned PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_HZ);

   localparam int unsigned CNT_W = 16;
   typedef logic [CNT_W-1:0] dbc_cnt_t;

   // Register byte offsets.
   localparam logic [7:0] REG_OFF_TIME   = 8'h00;
   localparam logic [7:0] REG_DEAD_TIME  = 8'h04;
   localparam logic [7:0] REG_BLANK_TIME = 8'h08;
   localparam logic [7:0] REG_MIN_ON     = 8'h0c;
   localparam logic [7:0] REG_STATUS     = 8'h10;

   localparam dbc_cnt_t RST_OFF   = dbc_cnt_t'(OFF_CYC);
   localparam dbc_cnt_t RST_DEAD  = dbc_cnt_t'(DEAD_CYC);
   localparam dbc_cnt_t RST_BLANK = dbc_cnt_t'(BLANK_CYC);
   localparam dbc_cnt_t RST_MINON = dbc_cnt_t'(MIN_ON_CYC);

   // Chopper phase of one bridge.
   typedef enum logic [2:0] {
      CH_IDLE,
      CH_ON,
      CH_DEAD_OFF,
      CH_RECIRC,
      CH_DEAD_ON
   } dbc_chop_e;

   // Programmed timing shared by both bridges.
   typedef struct packed {
      dbc_cnt_t offTime;
      dbc_cnt_t deadTime;
      dbc_cnt_t blankTime;
      dbc_cnt_t minOn;
   } dbc_timing_s;

   // Gate drive of one full bridge: high and low side of legs 1 and 2.
   typedef struct packed {
      logic hi1;
      logic lo1;
      logic hi2;
      logic lo2;
   } dbc_gates_s;

   // Sequencer inputs for one bridge.
   typedef struct packed {
      logic phase;
      logic enable;
   } dbc_seq_s;
endpackage
`default_nettype wire

// [tb/dbc_dual_chopper_assertions.sv]
// Purpose: Port-level checks for the dual chopper.
// Assumes: Dead time is programmed to 3 cycles or more.
// Notes:   Margins cover the two-stage input synchronisers.
`default_nettype none
module dbc_dual_chopper_assertions
   import dbc_pkg::*;
(
   input wire logic       clock,         // System clock.
   input wire logic       rst_n,         // Reset, active low.
   input wire logic       enLine_i,      // Enable line level.
   input wire logic       enLine_o,      // Enable drive value.
   input wire logic       enLine_oe_n,   // Pull-down, low drives.
   input wire logic       faultOver,     // Overcurrent fault.
   input wire logic       decaySel,      // Decay select.
   input wire dbc_seq_s   seqB,          // Sequencer of bridge B.
   input wire dbc_gates_s gatesA,        // Gates of bridge A.
   input wire dbc_gates_s gatesB,        // Gates of bridge B.
   input wire logic       pump_drive_out // Pump square wave.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] pumpCnt;
   logic       pumpSeen;
   logic       pumpLast;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Counts cycles since the pump output last changed.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pumpCnt  <= 5'h00;
         pumpSeen <= 1'b0;
         pumpLast <= 1'b0;
      end else begin
         pumpLast <= pump_drive_out;
         pumpCnt  <= (pump_drive_out != pumpLast) ? 5'h01 : pumpCnt + 5'h01;
         pumpSeen <= pumpSeen | (pump_drive_out != pumpLast);
      end
   end
   // Each property but p_odrv and p_pumpRun ties an output to its cause with a fixed margin.
   property p_deadA; $fell(gatesA.hi1) |-> (!gatesA.lo1) [*3]; endproperty
   a_deadA: assert property (p_deadA)
      else $error("low side on inside dead time");
   property p_enOff; (!enLine_i) [*4] |-> gatesA == 4'h0 && gatesB == 4'h0; endproperty
   a_enOff: assert property (p_enOff)
      else $error("gates on while enable line low");
   property p_pull; faultOver [*4] |-> !enLine_oe_n; endproperty
   a_pull: assert property (p_pull)
      else $error("fault did not pull enable low");
   property p_free; (!faultOver) [*4] |-> enLine_oe_n; endproperty
   a_free: assert property (p_free)
      else $error("enable pulled low without fault");
   property p_odrv; enLine_o == 1'b0; endproperty
   a_odrv: assert property (p_odrv)
      else $error("enable drive value not low");
   property p_pump; pumpSeen && $changed(pump_drive_out) |-> pumpCnt == 5'h10; endproperty
   a_pump: assert property (p_pump)
      else $error("pump half period wrong");
   property p_pumpRun; pumpCnt < 5'h12; endproperty
   a_pumpRun: assert property (p_pumpRun)
      else $error("pump output stopped");
   property p_seqOff; (!seqB.enable) [*4] |-> gatesB == 4'h0; endproperty
   a_seqOff: assert property (p_seqOff)
      else $error("bridge on with sequencer enable low");
   property p_fastHi; (!decaySel) [*6] |-> !(gatesA.hi1 && gatesA.hi2); endproperty
   a_fastHi: assert property (p_fastHi)
      else $error("both high sides on in fast decay");
endmodule
`default_nettype wire

// [tb/dbc_dual_chopper_tb.sv]
// Purpose: Self-checking bench for the dual chopper.
// Assumes: Timing registers are shortened over the bus.
// Notes:   Chopping cases run from a table.
`default_nettype none
module dbc_dual_chopper_tb
   import dbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OFFT  = 40;
   localparam int DEADT = 4;
   localparam int MINON = 10;
   typedef struct packed {
      logic b; logic ph; logic slow; dbc_gates_s on; dbc_gates_s dp; dbc_gates_s rp;
   } dbc_row_s;
   dbc_row_s    rows[4] = '{'{0, 1, 0, 4'h9, 4'h0, 4'h4}, '{0, 0, 0, 4'h6, 4'h0, 4'h1},
                            '{0, 1, 1, 4'h9, 4'h8, 4'ha}, '{1, 0, 1, 4'h6, 4'h2, 4'ha}};
   logic [7:0]  ra[4] = '{REG_OFF_TIME, REG_DEAD_TIME, REG_BLANK_TIME, REG_MIN_ON};
   logic [31:0] rr[4] = '{32'h84, 32'h14, 32'h14, 32'h1e};
   logic [31:0] rw[4] = '{32'habcd0028, 32'h04, 32'h06, 32'h0a};
   logic        clock = 0, rst_n = 0, wbWe = 0, wbCyc = 0, wbStb = 0, wbAck, enLine, enLineO;
   logic        enOeN, faultOver = 0, decaySel = 0, overRefA, overRefB, pump;
   logic        extPull = 0, stuckA = 0;
   logic [7:0]  wbAdr = 0;
   logic [31:0] wbDatI = 0, wbDatO, q;
   dbc_seq_s    seqA = '0, seqB = '0;
   dbc_gates_s  gatesA, gatesB, dp, rp;
   int          errorCnt = 0, checks = 0, cycles = 0, onLen, offLen;
   dbc_dual_chopper dut_u (.clock(clock), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(4'hf), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_ack_o(wbAck), .enLine_i(enLine), .enLine_o(enLineO), .enLine_oe_n(enOeN),
      .faultOver(faultOver), .decaySel(decaySel), .seqA(seqA), .seqB(seqB),
      .overRefA(overRefA), .overRefB(overRefB), .gatesA(gatesA), .gatesB(gatesB),
      .pump_drive_out(pump));
   dbc_motor_model model_u (.clock(clock), .gatesA(gatesA), .gatesB(gatesB),
      .enLine_o(enLineO), .enLine_oe_n(enOeN), .extPull(extPull), .stuckA(stuckA),
      .enLine(enLine), .overRefA(overRefA), .overRefB(overRefB));
   // Clock and hang guard.
   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 9000) begin
         errorCnt++;
         test_done();
      end
   end
   task automatic test_done();
      if (errorCnt == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cmpVal(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmpCnt(input string nm, input int e, input int g);
      cmpVal(nm, e, g);
   endtask
   // One classic Wishbone cycle, held until ack is sampled.
   task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      wbAdr  <= a;
      wbWe   <= w;
      wbDatI <= d;
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      @(posedge clock);
      while (wbAck !== 1'b1 && n < 100) begin
         n++;
         @(posedge clock);
      end
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (n >= 100) errorCnt++;
   endtask
   function automatic dbc_gates_s gsel(input logic b);
      return b ? gatesB : gatesA;
   endfunction
   // Holds the line low while mode and phase change, then releases it.
   task automatic arm(input dbc_row_s r);
      extPull <= 1'b1;
      repeat (8) @(posedge clock);
      decaySel <= r.slow;
      seqA     <= '{r.ph, !r.b};
      seqB     <= '{r.ph, r.b};
      repeat (8) @(posedge clock);
      extPull <= 1'b0;
   endtask
   // Measures one on run and the following off run of a bridge.
   task automatic measure(input logic b, input dbc_gates_s on);
      int n;
      n = 0;
      onLen = 0;
      offLen = 0;
      while (gsel(b) !== on && n < 2000) begin
         n++;
         @(posedge clock);
      end
      while (gsel(b) === on && n < 2000) begin
         onLen++;
         n++;
         @(posedge clock);
      end
      while (gsel(b) !== on && n < 2000) begin
         if (offLen == 1) dp = gsel(b);
         if (offLen == DEADT + 2) rp = gsel(b);
         offLen++;
         n++;
         @(posedge clock);
      end
      if (n >= 2000) errorCnt++;
   endtask
   // Main sequence: registers, table of cases, then the awkward cases.
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wbXfer(ra[i], 1'b0, 32'h0);
         cmpVal("regReset", rr[i], q);
         wbXfer(ra[i], 1'b1, rw[i]);
         wbXfer(ra[i], 1'b0, 32'h0);
         cmpVal("regWrite", {16'h0, rw[i][15:0]}, q);
      end
      wbXfer(8'h14, 1'b1, 32'h5a5a);
      wbXfer(8'h14, 1'b0, 32'h0);
      cmpVal("unmapped", 32'h0, q);
      foreach (rows[i]) begin
         arm(rows[i]);
         measure(rows[i].b, rows[i].on);
         cmpCnt("onMin", 1, int'(onLen >= MINON));
         cmpCnt("offLen", OFFT + DEADT, offLen);
         cmpVal("deadPat", rows[i].dp, dp);
         cmpVal("recPat", rows[i].rp, rp);
      end
      wbXfer(REG_BLANK_TIME, 1'b1, 32'h0c);
      stuckA <= 1'b1;
      arm(rows[0]);
      measure(1'b0, rows[0].on);
      cmpCnt("onBlank", 1, int'(onLen >= 12 && onLen <= 16));
      stuckA    <= 1'b0;
      faultOver <= 1'b1;
      repeat (8) @(posedge clock);
      cmpVal("pullDown", 32'h0, enOeN);
      cmpVal("enLine", 32'h0, enLine);
      cmpVal("gatesOff", 32'h0, gatesA);
      wbXfer(REG_STATUS, 1'b0, 32'h0);
      cmpVal("status", 32'h200, q);
      faultOver <= 1'b0;
      repeat (6) @(posedge clock);
      cmpVal("release", 32'h1, enOeN);
      test_done();
   end
endmodule
bind dbc_dual_chopper dbc_dual_chopper_assertions chk_u (.clock(clock), .rst_n(rst_n),
   .enLine_i(enLine_i), .enLine_o(enLine_o), .enLine_oe_n(enLine_oe_n),
   .faultOver(faultOver), .decaySel(decaySel), .seqB(seqB), .gatesA(gatesA),
   .gatesB(gatesB), .pump_drive_out(pump_drive_out));
`default_nettype wire

// [tb/dbc_motor_model.sv]
// Purpose: Winding current and enable network beside the chopper.
// Assumes: Current ramps one unit per cycle, linear.
// Notes:   Sense A can be stuck high on command.
`default_nettype none
module dbc_motor_model
   import dbc_pkg::*;
#(
   parameter int TRIP = 30               // Current where sense passes reference.
)
(
   input  wire logic       clock,        // System clock.
   input  wire dbc_gates_s gatesA,       // Gates of bridge A.
   input  wire dbc_gates_s gatesB,       // Gates of bridge B.
   input  wire logic       enLine_o,     // Device drive value.
   input  wire logic       enLine_oe_n,  // Device pull-down, low drives.
   input  wire logic       extPull,      // Controller pulls the line low.
   input  wire logic       stuckA,       // Sense A stuck above reference.
   output wire logic       enLine,       // Resolved enable line.
   output var  logic       overRefA,     // Sense A above reference.
   output var  logic       overRefB      // Sense B above reference.
);
   timeunit 1ns;
   timeprecision 1ps;
   int curA = 0;
   int curB = 0;
   // Current grows on the energised diagonal and decays otherwise.
   function automatic int step(dbc_gates_s g, int c);
      if ((g.hi1 && g.lo2) || (g.hi2 && g.lo1)) return c + 1;
      return (c > 0) ? c - 1 : 0;
   endfunction
   // Pull-up on the wired-low node; either party may pull it down.
   assign enLine = !extPull && (enLine_oe_n || enLine_o);
   initial begin
      overRefA = 1'b0;
      overRefB = 1'b0;
   end
   // Comparators follow the modelled currents.
   always @(posedge clock) begin
      curA     <= step(gatesA, curA);
      curB     <= step(gatesB, curB);
      overRefA <= stuckA || (curA >= TRIP);
      overRefB <= curB >= TRIP;
   end
endmodule
`default_nettype wire
